/* File: hdl/dbs_pkg.sv */
package dbs_pkg;
    // input terminal function codes
    localparam logic [7:0] FUNC_EXT_BRAKE  = 8'h07;
    localparam logic [7:0] FUNC_ALT_MOTOR  = 8'h08;
    localparam int         NUM_SLOTS       = 5;
    // register map (byte addresses)
    localparam logic [7:0] ADDR_SLOT_BASE  = 8'h00;  // slots one..five at 00..10
    localparam logic [7:0] ADDR_DELAY      = 8'h14;
    localparam logic [7:0] ADDR_FORCE      = 8'h18;
    localparam logic [7:0] ADDR_CTRL       = 8'h1c;
    localparam logic [7:0] ADDR_STATUS     = 8'h20;
    // fields
    localparam int         CTRL_KEYPAD_BIT = 0;
    localparam int         CTRL_RUN_BIT    = 1;
    localparam int         CTRL_STOPPED_BIT = 2;
    // limits and reset values
    localparam logic [7:0] DELAY_MAX_TENTHS = 8'h32;  // 5.0 s in 0.1 s units
    localparam logic [7:0] FORCE_MAX_PCT    = 8'h64;  // 100 percent
    localparam logic [7:0] SLOT_RST         = 8'h00;
    localparam logic [7:0] DELAY_RST        = 8'h00;
    localparam logic [7:0] FORCE_RST        = 8'h00;
    // timing
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         TICK_MS         = 100;
    localparam int         TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // brake sequencer states
    typedef enum logic [1:0] {
        DBS_DRIVE   = 2'b00,
        DBS_COAST   = 2'b01,
        DBS_BRAKE   = 2'b10,
        DBS_OFF     = 2'b11
    } dbs_state_e;
endpackage : dbs_pkg

/* File: hdl/dbs_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module dbs_tick_gen #(
    parameter int TICK_CYCLES = 5_000_000
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // tick
    output logic      tick
);
    // a one-cycle period would leave the tick stuck high
    if (TICK_CYCLES < 2) begin : g_bad_period
        $error("tick period too short");
    end

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        tick_ff;
    logic        nxt_tick;

    always_comb begin
        nxt_tick = (cnt_ff == 32'(TICK_CYCLES - 1));
        nxt_cnt  = nxt_tick ? 32'h0 : cnt_ff + 32'h1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule // dbs_tick_gen
`default_nettype wire

/* File: hdl/dbs_brake_motor_set.sv */
// Functional notes
// - any of five slots takes codes 07/08
// - brake delay 0.0 to 5.0 seconds
// - brake force 0 to 100 percent
// - terminal run: brake, then ramp back
// - keypad run: brake, then output stays off
// - nonzero delay: coast, then brake
// - alternate input selects second motor set
// - motor set changes only while stopped
// - deasserted alternate input returns main set
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dbs_brake_motor_set
    import dbs_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // terminal pins, five intelligent inputs and run terminals
    input  wire logic [4:0] term_in,
    input  wire logic       forward_run_input,
    input  wire logic       reverse_run_input,
    // output stage
    output logic            drive_enable,
    output logic            dc_brake_on,
    output logic      [7:0] dc_brake_level,
    output logic            ramp_restore,
    output logic            motor_set_sel
);
    // refused at elaboration: the tick divider cannot run below two cycles
    if (TICK_CYC < 2) begin : g_bad_tick
        $error("tick period too short");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [6:0] pin_s1_ff;
    logic [6:0] pin_s2_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_s1_ff <= 7'h0;
            pin_s2_ff <= 7'h0;
        end else begin
            pin_s1_ff <= {reverse_run_input, forward_run_input, term_in};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    logic [4:0] term_s;
    logic       term_run;
    assign term_s   = pin_s2_ff[4:0];
    assign term_run = pin_s2_ff[5] | pin_s2_ff[6];

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] slot_func_ff [NUM_SLOTS];
    logic [7:0] delay_ff;
    logic [7:0] force_ff;
    logic [2:0] ctrl_ff;
    logic [7:0] nxt_delay;
    logic [7:0] nxt_force;
    logic [2:0] nxt_ctrl;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            logic [7:0] nxt_slot;
            always_comb begin
                nxt_slot = slot_func_ff[gi];
                if (reg_wr && reg_addr == ADDR_SLOT_BASE + 8'(4 * gi))
                    nxt_slot = reg_wdata;
            end
            always_ff @(posedge mclk) begin
                if (reset)
                    slot_func_ff[gi] <= SLOT_RST;
                else
                    slot_func_ff[gi] <= nxt_slot;
            end
        end
    endgenerate

    // slot mapping: an input function is on if any slot carrying its code is on
    logic brake_req;
    logic alt_req;
    always_comb begin
        brake_req = 1'b0;
        alt_req   = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_func_ff[i] == FUNC_EXT_BRAKE && term_s[i])
                brake_req = 1'b1;
            if (slot_func_ff[i] == FUNC_ALT_MOTOR && term_s[i])
                alt_req = 1'b1;
        end
    end

    // out of range writes saturate so the limits always hold
    always_comb begin
        nxt_delay = delay_ff;
        nxt_force = force_ff;
        nxt_ctrl  = ctrl_ff;
        if (reg_wr && reg_addr == ADDR_DELAY)
            nxt_delay = (reg_wdata > DELAY_MAX_TENTHS) ? DELAY_MAX_TENTHS : reg_wdata;
        if (reg_wr && reg_addr == ADDR_FORCE)
            nxt_force = (reg_wdata > FORCE_MAX_PCT) ? FORCE_MAX_PCT : reg_wdata;
        if (reg_wr && reg_addr == ADDR_CTRL)
            nxt_ctrl = reg_wdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // brake sequencer
    dbs_state_e state_ff;
    dbs_state_e nxt_state;
    logic [7:0] dly_cnt_ff;
    logic [7:0] nxt_dly_cnt;
    logic       tick;
    logic       brake_d_ff;
    logic       set_ff;
    logic       nxt_set;
    logic       keypad_mode;
    logic       run_cmd;
    logic       stopped;

    assign keypad_mode = ctrl_ff[CTRL_KEYPAD_BIT];
    assign run_cmd     = keypad_mode ? ctrl_ff[CTRL_RUN_BIT] : term_run;
    assign stopped     = ctrl_ff[CTRL_STOPPED_BIT];

    dbs_tick_gen #(
        .TICK_CYCLES (TICK_CYC)
    ) u_tick (
        .mclk  (mclk),
        .reset (reset),
        .tick  (tick)
    );

    always_comb begin
        nxt_state   = state_ff;
        nxt_dly_cnt = dly_cnt_ff;
        unique case (state_ff)
            DBS_DRIVE: begin
                if (brake_req && !brake_d_ff) begin
                    nxt_dly_cnt = delay_ff;
                    nxt_state   = (delay_ff != 8'h0) ? DBS_COAST : DBS_BRAKE;
                end
            end
            DBS_COAST: begin
                if (!brake_req)
                    nxt_state = keypad_mode ? DBS_OFF : DBS_DRIVE;
                else if (tick) begin
                    nxt_dly_cnt = dly_cnt_ff - 8'h1;
                    if (dly_cnt_ff == 8'h1)
                        nxt_state = DBS_BRAKE;
                end
            end
            DBS_BRAKE: begin
                if (!brake_req)
                    nxt_state = keypad_mode ? DBS_OFF : DBS_DRIVE;
            end
            DBS_OFF: begin
                // keypad stop latches off until the run command drops
                if (!run_cmd)
                    nxt_state = DBS_DRIVE;
            end
        endcase
    end

    // motor set: follows the input only while stopped
    always_comb begin
        nxt_set = set_ff;
        if (stopped)
            nxt_set = alt_req;
    end

    always_comb begin
        nxt_rdata = 8'h0;
        if (reg_rd) begin
            for (int i = 0; i < NUM_SLOTS; i++)
                if (reg_addr == ADDR_SLOT_BASE + 8'(4 * i))
                    nxt_rdata = slot_func_ff[i];
            if (reg_addr == ADDR_DELAY)
                nxt_rdata = delay_ff;
            if (reg_addr == ADDR_FORCE)
                nxt_rdata = force_ff;
            if (reg_addr == ADDR_CTRL)
                nxt_rdata = {5'h0, ctrl_ff};
            if (reg_addr == ADDR_STATUS)
                nxt_rdata = {3'h0, set_ff, alt_req, brake_req, state_ff};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            delay_ff   <= DELAY_RST;
            force_ff   <= FORCE_RST;
            ctrl_ff    <= 3'h0;
            state_ff   <= DBS_DRIVE;
            dly_cnt_ff <= 8'h0;
            brake_d_ff <= 1'b0;
            set_ff     <= 1'b0;
            rdata_ff   <= 8'h0;
        end else begin
            delay_ff   <= nxt_delay;
            force_ff   <= nxt_force;
            ctrl_ff    <= nxt_ctrl;
            state_ff   <= nxt_state;
            dly_cnt_ff <= nxt_dly_cnt;
            brake_d_ff <= brake_req;
            set_ff     <= nxt_set;
            rdata_ff   <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        drive_enable   = (state_ff == DBS_DRIVE) && run_cmd;
        dc_brake_on    = (state_ff == DBS_BRAKE);
        dc_brake_level = (state_ff == DBS_BRAKE) ? force_ff : 8'h0;
        ramp_restore   = (state_ff == DBS_DRIVE);
        motor_set_sel  = set_ff;
        reg_rdata      = rdata_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_coast_no_brake: assert property (@(posedge mclk) disable iff (reset)
        state_ff == DBS_COAST && brake_req && !(tick && dly_cnt_ff == 8'h1) |=> !dc_brake_on && !drive_enable)
        else $error("brake or drive before delay expired");
    chk_zero_delay_brake: assert property (@(posedge mclk) disable iff (reset)
        state_ff == DBS_DRIVE && brake_req && !brake_d_ff && delay_ff == 8'h0 |=> dc_brake_on)
        else $error("zero delay did not brake at once");
    chk_keypad_off: assert property (@(posedge mclk) disable iff (reset)
        state_ff == DBS_BRAKE && !brake_req && keypad_mode |=> state_ff == DBS_OFF)
        else $error("keypad release did not hold output off");
    chk_term_resume: assert property (@(posedge mclk) disable iff (reset)
        state_ff == DBS_BRAKE && !brake_req && !keypad_mode |=> ramp_restore)
        else $error("terminal release did not resume");
    chk_set_hold_run: assert property (@(posedge mclk) disable iff (reset)
        !$past(stopped) |-> $stable(set_ff))
        else $error("motor set changed while running");
    chk_set_follow: assert property (@(posedge mclk) disable iff (reset)
        stopped |=> set_ff == $past(alt_req))
        else $error("motor set did not follow input when stopped");
    chk_delay_limit: assert property (@(posedge mclk) disable iff (reset)
        delay_ff <= DELAY_MAX_TENTHS)
        else $error("delay above limit");
    chk_force_level: assert property (@(posedge mclk) disable iff (reset)
        dc_brake_on |-> dc_brake_level == force_ff && force_ff <= FORCE_MAX_PCT)
        else $error("brake level wrong");
    chk_off_no_drive: assert property (@(posedge mclk) disable iff (reset)
        state_ff == DBS_OFF && run_cmd |=> !drive_enable && !dc_brake_on)
        else $error("output resumed after keypad release");
endmodule // dbs_brake_motor_set
`default_nettype wire

/* File: tb/dbs_term_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dbs_term_model (
    // clock
    input  wire logic       mclk,
    // terminals toward the device
    output logic      [4:0] term_in,
    output logic            forward_run_input,
    output logic            reverse_run_input
);
    logic [4:0] pin_ff   = 5'h00;
    logic [4:0] brk_mask = 5'h00;
    logic       fwd_ff   = 1'b0;
    logic       rev_ff   = 1'b0;
    int         hold_cnt = 0;
    // contacts change just after an edge; bm marks the slots wired as brake inputs
    task automatic set_pins(input logic [4:0] t, input logic [4:0] bm, input logic f, input logic r);
        @(posedge mclk);
        pin_ff <= t;
        brk_mask <= bm;
        fwd_ff <= f;
        rev_ff <= r;
    endtask
    always @(posedge mclk)
        hold_cnt <= ((pin_ff & brk_mask) != 5'h00) ? hold_cnt + 1 : 0;
    // never used as a holding brake: the brake contact opens after a bounded time
    assign term_in           = (hold_cnt > 200) ? (pin_ff & ~brk_mask) : pin_ff;
    assign forward_run_input = fwd_ff;
    assign reverse_run_input = rev_ff;
endmodule // dbs_term_model
`default_nettype wire

/* File: tb/dbs_brake_motor_set_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dbs_brake_motor_set_test;
    import dbs_pkg::*;
    localparam int TK = 10;
    logic       mclk, reset, reg_wr, reg_rd, fwd, rev;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dc_brake_level;
    logic [4:0] term_in;
    logic       drive_enable, dc_brake_on, ramp_restore, motor_set_sel;
    int         num_errors, checks_done;
    dbs_term_model pm_u (.mclk(mclk), .term_in(term_in), .forward_run_input(fwd), .reverse_run_input(rev));
    dbs_brake_motor_set #(.TICK_CYC(TK)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_in(term_in),
        .forward_run_input(fwd), .reverse_run_input(rev), .drive_enable(drive_enable),
        .dc_brake_on(dc_brake_on), .dc_brake_level(dc_brake_level), .ramp_restore(ramp_restore),
        .motor_set_sel(motor_set_sel));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, e);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        num_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chkb(ramp_restore, 1'b1);
        chkb(dc_brake_on, 1'b0);
        rchk(ADDR_DELAY, DELAY_RST);
        rchk(ADDR_FORCE, FORCE_RST);
        rchk(8'h30, 8'h00);
        wr(ADDR_DELAY, 8'h40);
        rchk(ADDR_DELAY, DELAY_MAX_TENTHS);
        wr(ADDR_FORCE, 8'hff);
        rchk(ADDR_FORCE, FORCE_MAX_PCT);
        $display("test registers done");
        // terminal run, every slot, zero delay, run source alternating forward/reverse
        wr(ADDR_DELAY, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            wr(ADDR_SLOT_BASE + 8'(4 * i), FUNC_EXT_BRAKE);
            wr(ADDR_FORCE, 8'(20 * i + 10));
            pm_u.set_pins(5'h00, 5'h00, ~i[0], i[0]);
            cyc(6);
            chkb(drive_enable, 1'b1);
            pm_u.set_pins(5'h01 << i, 5'h01 << i, ~i[0], i[0]);
            cyc(6);
            chkb(dc_brake_on, 1'b1);
            chk8(dc_brake_level, 8'(20 * i + 10));
            pm_u.set_pins(5'h00, 5'h00, ~i[0], i[0]);
            cyc(6);
            chkb(dc_brake_on, 1'b0);
            chkb(ramp_restore, 1'b1);
            chkb(drive_enable, 1'b1);
            wr(ADDR_SLOT_BASE + 8'(4 * i), SLOT_RST);
        end
        $display("test terminal run done");
        // keypad run with three ticks of coasting before braking
        pm_u.set_pins(5'h00, 5'h00, 1'b0, 1'b0);
        wr(ADDR_SLOT_BASE + 8'h08, FUNC_EXT_BRAKE);
        rchk(ADDR_SLOT_BASE + 8'h08, FUNC_EXT_BRAKE);
        wr(ADDR_DELAY, 8'h03);
        wr(ADDR_CTRL, 8'h03);
        pm_u.set_pins(5'h04, 5'h04, 1'b0, 1'b0);
        cyc(15);
        chkb(drive_enable, 1'b0);
        chkb(dc_brake_on, 1'b0);
        cyc(3 * TK + 5);
        chkb(dc_brake_on, 1'b1);
        pm_u.set_pins(5'h00, 5'h00, 1'b0, 1'b0);
        cyc(6);
        chkb(dc_brake_on, 1'b0);
        chkb(drive_enable, 1'b0);
        chkb(ramp_restore, 1'b0);
        rchk(ADDR_STATUS, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_SLOT_BASE + 8'h08, SLOT_RST);
        $display("test keypad run done");
        // motor set follows its input only while stopped
        wr(ADDR_SLOT_BASE + 8'h10, FUNC_ALT_MOTOR);
        pm_u.set_pins(5'h10, 5'h00, 1'b0, 1'b0);
        cyc(6);
        chkb(motor_set_sel, 1'b0);
        wr(ADDR_CTRL, 8'h04);
        cyc(4);
        chkb(motor_set_sel, 1'b1);
        wr(ADDR_CTRL, 8'h00);
        pm_u.set_pins(5'h00, 5'h00, 1'b0, 1'b0);
        cyc(6);
        chkb(motor_set_sel, 1'b1);
        wr(ADDR_CTRL, 8'h04);
        cyc(4);
        chkb(motor_set_sel, 1'b0);
        $display("test motor set done");
        test_done();
    end
endmodule // dbs_brake_motor_set_test
`default_nettype wire
